// [shared/fll_pkg.sv]
// Constants shared by the tuning controller and its helpers.
// Assumes a 250 MHz system clock; all times are converted to cycles here.
`default_nettype none
package fll_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS  = 4;          // System clock period
   localparam int CYCLE_TIME_NS  = 2560000;    // Measure-and-correct cycle
   localparam int PROC_TIME_NS   = 1280000;    // Processing part of cycle
   localparam int MIN_PULSE_NS   = 2000;       // Shortest correction pulse
   localparam int CYCLE_CYC      = CYCLE_TIME_NS / CLK_PERIOD_NS;
   localparam int PROC_CYC       = PROC_TIME_NS / CLK_PERIOD_NS;
   localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_OSC_KHZ    = 4000;       // Reference oscillator rate
   localparam int PRESCALE_RATIO = 64;         // Oscillator division ratio
   localparam int PRESCALE_BITS  = 6;          // Bits of that divider

   // ==========================================================
   // Widths, windows (in 50 kHz steps) and reset values
   localparam int              FREQ_W      = 15;
   localparam int              CNT_W       = 20;
   localparam logic [14:0]     WIN_DIG     = 15'h0004;  // +/-200 kHz
   localparam logic [14:0]     WIN_AFC     = 15'h0010;  // +/-800 kHz
   localparam logic [14:0]     FREQ_RST    = 15'h7fff;  // All ones at reset
   localparam logic [2:0]      GAIN_MAX    = 3'h6;      // Top gain code
   localparam logic [3:0]      BAND_RST    = 4'h0;

   // ==========================================================
   // Serial bus: address and instruction codes (values arbitrary)
   localparam logic [4:0]      ADDR_HI     = 5'h18;     // Arbitrary value
   localparam logic [7:0]      INSTR_CTRL  = 8'h01;     // Arbitrary value
   localparam logic [7:0]      INSTR_BAND  = 8'h02;     // Arbitrary value

   // ==========================================================
   // Control byte field positions
   localparam int CTL_HOLD   = 0;
   localparam int CTL_GAIN_L = 1;
   localparam int CTL_AFC    = 4;
   localparam int CTL_WIN    = 5;
   localparam int CTL_AGAIN  = 6;

   // ==========================================================
   // Status byte bit positions
   localparam int ST_LOCK  = 7;
   localparam int ST_RISE  = 6;
   localparam int ST_FALL  = 5;
   localparam int ST_OVF   = 4;
   localparam int ST_RSEEN = 3;
   localparam int ST_MWIN  = 2;
   localparam int ST_AFC   = 1;

   // Serial slave states
   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX} i2c_state_type;
endpackage
`default_nettype wire

// [hw/sync_2ff.sv]
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or edge seen by the system clock.
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;   // First stage, read only by second

   // ==========================================================
   // Two stages
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [hw/osc_prescaler.sv]
// Divide-by-64 prescaler on a synchronised oscillator level.
// Assumes the input already passed a synchroniser on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module osc_prescaler
   import fll_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic osc_level,
   output logic      divided_osc,
   output logic      div_tick
);
   logic                     prev_r;   // Last sampled level
   logic [PRESCALE_BITS-1:0] div_r;    // Edge divider
   wire                      rise = osc_level & ~prev_r;

   // ==========================================================
   // Count rising edges, one tick per 64
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_r      <= 1'b0;
         div_r       <= '0;
         div_tick    <= 1'b0;
         divided_osc <= 1'b0;
      end else begin
         prev_r      <= osc_level;
         div_tick    <= rise & (&div_r);
         if (rise) begin
            div_r <= div_r + 1'b1;
         end
         divided_osc <= div_r[PRESCALE_BITS-1];
      end
   end
endmodule
`default_nettype wire

// [hw/fll_tuning_controller.sv]
// Frequency-locked-loop tuning controller with two-wire serial slave.
// Assumes oscillator, bus and band-port levels arrive asynchronously.
//
// Operation
// - Divide oscillator by 64 before counting
// - Count against 15-bit target, 50 kHz steps
// - 2.56 ms cycle; pulse within one cycle
// - Correction charge follows error, saturating at 7
// - Hold bit selects full or reduced current
// - Gain code doubles pulse, minimum 2 us
// - AFC request bit selects tuning mode
// - Leaving 800 kHz range drops AFC
// - Window bit selects 0 or 200 kHz
// - Lock flag when inside active window
// - Lock edge flags low, cleared by read
// - Overflow flag when oscillator too high
// - Reset-seen flag low until status read
// - Measuring-window flag high while processing
// - AFC-mode flag mirrors tuning mode
// - One bit selects AFC amplifier gain
// - Band outputs low when bit set
// - Top instruction bit writes frequency
// - Subaddress matched against band port level
// - Acknowledge valid address outside reset only
// - Read returns exactly one status byte
`timescale 1ns/1ns
`default_nettype none
module fll_tuning_controller
   import fll_pkg::*;
#(
   parameter int CYCLE_LEN = fll_pkg::CYCLE_CYC,   // Cycle in clocks
   parameter int PROC_LEN  = fll_pkg::PROC_CYC     // Processing part
) (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       osc_in_pos,       // Oscillator, true side
   input  wire logic       osc_in_neg,       // Oscillator, complement
   input  wire logic       scl,              // Bus clock
   input  wire logic       sda_in,           // Bus data level
   output logic            sda_out,          // Always low when driven
   output logic            sda_oe,           // High pulls line low
   input  wire logic       band_port_0_lo,   // Port 0 seen near ground
   input  wire logic       band_port_0_hi,   // Port 0 seen near supply
   output logic [3:0]      band_ports_n,     // Band outputs, low active
   output logic            divided_osc,      // Prescaler output
   output logic            charge_up,        // Raise tuning voltage
   output logic            charge_down,      // Lower tuning voltage
   output logic [2:0]      correction_charge,// Converter code
   output logic            hold_current_n,   // 1 = full current
   output logic            afc_gain_sel,     // 1 = low transconductance
   output logic            afc_mode_flag,    // 1 = AFC tuning
   output logic            lock_flag,
   output logic            measure_window_n
);
   import fll_pkg::*;

   // ==========================================================
   // Synchronised inputs
   logic [5:0] sync_q;                 // Synchronised pins
   logic       osc_s, scl_s, sda_s, p0_lo, p0_hi, osc_n_s;
   logic       div_tick;               // One per 64 oscillator edges

   sync_2ff #(.W(6)) u_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in ({osc_in_pos, osc_in_neg, ~scl, ~sda_in, band_port_0_lo, band_port_0_hi}),
      .sync_out (sync_q)
   );
   // Bus lines held inverted so they leave reset at their idle high
   assign {osc_s, osc_n_s, scl_s, sda_s, p0_lo, p0_hi} = sync_q ^ 6'h0c;

   osc_prescaler u_pre (
      .sys_clk     (sys_clk),
      .arst_n      (arst_n),
      .osc_level   (osc_s & ~osc_n_s),
      .divided_osc (divided_osc),
      .div_tick    (div_tick)
   );

   // ==========================================================
   // Programmed state
   logic [14:0] freq_buf_r;            // Target in 50 kHz steps
   logic [2:0]  loop_gain_sel_r;       // Pulse scaling code
   logic        hold_r, afc_req_r, win_r, again_r;
   logic [3:0]  band_r;                // Band bits, 1 = active

   // Measurement state
   logic [CNT_W-1:0] cyc_r;            // Position inside cycle
   logic [14:0]      fcount_r;         // Gated oscillator count
   logic [14:0]      meas_r;           // Latched count
   logic             eval_r;           // Evaluate latched count
   logic [CNT_W-1:0] pulse_r;          // Remaining pulse clocks
   logic             dir_up_r;         // Pulse direction
   logic             ovf_r, lock_r, rise_n_r, fall_n_r, rseen_n_r;

   // Serial slave state
   i2c_state_type state_r;
   logic [7:0]  sh_r;                  // Receive shift
   logic [7:0]  tx_r;                  // Transmit shift
   logic [7:0]  instr_r;               // Instruction byte
   logic [3:0]  bit_r;                 // Bits in current byte
   logic [1:0]  byte_r;                // Byte index in frame
   logic        rw_r, scl_d, sda_d;
   logic        commit_r;              // Data byte complete
   logic        read_r;                // Status byte loaded

   // ==========================================================
   // Bus event decode
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   wire [1:0] subaddr  = sh_r[2:1];
   wire       level_ok = (subaddr == 2'b00) |
                         ((subaddr == 2'b01) & p0_lo) |
                         ((subaddr == 2'b10) & ~p0_lo & ~p0_hi) |
                         ((subaddr == 2'b11) & p0_hi);
   wire       addr_ok  = (sh_r[7:3] == ADDR_HI) & level_ok;

   wire [7:0] status;
   assign status[ST_LOCK]  = lock_r;
   assign status[ST_RISE]  = rise_n_r;
   assign status[ST_FALL]  = fall_n_r;
   assign status[ST_OVF]   = ovf_r;
   assign status[ST_RSEEN] = rseen_n_r;
   assign status[ST_MWIN]  = measure_window_n;
   assign status[ST_AFC]   = afc_req_r;
   assign status[0]        = 1'b0;

   // ==========================================================
   // Edge history of bus lines
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // ==========================================================
   // Serial slave sequencer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r  <= S_IDLE;
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         instr_r  <= 8'h00;
         bit_r    <= 4'h0;
         byte_r   <= 2'h0;
         rw_r     <= 1'b0;
         commit_r <= 1'b0;
         read_r   <= 1'b0;
      end else begin
         commit_r <= 1'b0;
         read_r   <= 1'b0;
         if (start_c) begin
            state_r <= S_RX;
            bit_r   <= 4'h0;
            byte_r  <= 2'h0;
         end else if (stop_c) begin
            state_r <= S_IDLE;
         end else begin
            case (state_r)
               S_RX: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda_s};
                     bit_r <= bit_r + 4'h1;
                  end else if (scl_fall && bit_r == 4'h8) begin
                     bit_r  <= 4'h0;
                     byte_r <= byte_r + 2'h1;
                     case (byte_r)
                        2'h0: begin
                           state_r <= addr_ok ? S_ACK : S_IDLE;
                           rw_r    <= sh_r[0];
                        end
                        2'h1: begin
                           instr_r <= sh_r;
                           state_r <= S_ACK;
                        end
                        2'h2: begin
                           commit_r <= 1'b1;
                           state_r  <= S_ACK;
                        end
                        default: begin
                           state_r <= S_IDLE;
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (rw_r) begin
                        // one status byte, flags then cleared
                        tx_r    <= status;
                        read_r  <= 1'b1;
                        state_r <= S_TX;
                     end else begin
                        state_r <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     tx_r  <= {tx_r[6:0], 1'b1};
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == 4'h7) begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Data line drive, registered
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= (state_r == S_ACK) | ((state_r == S_TX) & ~tx_r[7]);
      end
   end
   assign sda_out = 1'b0;

   // ==========================================================
   // Measurement error decode
   wire [15:0] diff     = {1'b0, meas_r} - {1'b0, freq_buf_r};
   wire        too_high = meas_r > freq_buf_r;
   wire [14:0] abs_err  = too_high ? diff[14:0] : (freq_buf_r - meas_r);
   wire [14:0] window   = afc_req_r ? WIN_AFC : (win_r ? WIN_DIG : 15'h0000);
   wire        lock_nxt = abs_err <= window;
   wire        afc_drop = afc_req_r & (abs_err > WIN_AFC);
   // gain code, unused top code clamps
   wire [2:0]  gain_eff = (loop_gain_sel_r > GAIN_MAX) ? GAIN_MAX : loop_gain_sel_r;
   wire [31:0] pulse_raw = (32'(abs_err) * 32'(MIN_PULSE_CYC)) << gain_eff;
   wire [CNT_W-1:0] pulse_nxt = (pulse_raw >= 32'(CYCLE_LEN)) ?
                                CNT_W'(CYCLE_LEN - 1) : pulse_raw[CNT_W-1:0];
   wire        cyc_end  = cyc_r == CNT_W'(CYCLE_LEN - 1);

   // ==========================================================
   // Register writes from the bus; AFC request dropped by loop
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_buf_r      <= FREQ_RST;
         loop_gain_sel_r <= 3'h0;
         hold_r          <= 1'b0;
         afc_req_r       <= 1'b0;
         win_r           <= 1'b0;
         again_r         <= 1'b0;
         band_r          <= BAND_RST;
      end else begin
         if (eval_r && afc_drop) begin
            afc_req_r <= 1'b0;
         end
         if (commit_r) begin
            if (instr_r[7]) begin
               freq_buf_r <= {instr_r[6:0], sh_r};
            end else if (instr_r == INSTR_CTRL) begin
               hold_r          <= sh_r[CTL_HOLD];
               loop_gain_sel_r <= sh_r[CTL_GAIN_L +: 3];
               afc_req_r       <= sh_r[CTL_AFC];
               win_r           <= sh_r[CTL_WIN];
               again_r         <= sh_r[CTL_AGAIN];
            end else if (instr_r == INSTR_BAND) begin
               band_r <= sh_r[3:0];
            end
         end
      end
   end

   // ==========================================================
   // Cycle timer and gated count
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_r    <= '0;
         fcount_r <= 15'h0000;
         meas_r   <= 15'h0000;
         eval_r   <= 1'b0;
      end else begin
         eval_r <= cyc_end;
         cyc_r  <= cyc_end ? '0 : cyc_r + 1'b1;
         if (cyc_end) begin
            meas_r   <= fcount_r;
            fcount_r <= 15'h0000;
         end else if (!measure_window_n && div_tick && fcount_r != 15'h7fff) begin
            fcount_r <= fcount_r + 15'h0001;
         end
      end
   end

   assign measure_window_n = cyc_r < CNT_W'(PROC_LEN);

   // ==========================================================
   // Evaluation and correction pulse
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_r           <= '0;
         dir_up_r          <= 1'b0;
         ovf_r             <= 1'b0;
         lock_r            <= 1'b0;
         correction_charge <= 3'h0;
      end else begin
         if (eval_r) begin
            ovf_r    <= too_high;
            lock_r   <= lock_nxt;
            dir_up_r <= ~too_high;
            correction_charge <= (abs_err > 15'h0007) ? 3'h7 : abs_err[2:0];
            pulse_r  <= afc_req_r ? '0 : pulse_nxt;
         end else if (pulse_r != '0) begin
            pulse_r <= pulse_r - 1'b1;
         end
      end
   end

   // ==========================================================
   // Sticky read flags, event wins over read
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_n_r  <= 1'b1;
         fall_n_r  <= 1'b1;
         rseen_n_r <= 1'b0;
      end else begin
         if (eval_r && lock_nxt && !lock_r) begin
            rise_n_r <= 1'b0;
         end else if (read_r) begin
            rise_n_r <= 1'b1;
         end
         if (eval_r && !lock_nxt && lock_r) begin
            fall_n_r <= 1'b0;
         end else if (read_r) begin
            fall_n_r <= 1'b1;
         end
         if (read_r) begin
            rseen_n_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign charge_up      = (pulse_r != '0) & dir_up_r;
   assign charge_down    = (pulse_r != '0) & ~dir_up_r;
   assign hold_current_n = hold_r;
   assign afc_gain_sel   = again_r;
   assign afc_mode_flag  = afc_req_r;
   assign lock_flag      = lock_r;
   assign band_ports_n   = ~band_r;
endmodule
`default_nettype wire

// [verification/fll_tuning_controller_asserts.sv]
// Port checker for the tuning controller.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module fll_tuning_controller_asserts
   import fll_pkg::*;
#(
   parameter int CYCLE_LEN = CYCLE_CYC,
   parameter int PROC_LEN  = PROC_CYC
) (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic       scl,
   input wire logic       sda_oe,
   input wire logic [3:0] band_ports_n,
   input wire logic       charge_up,
   input wire logic       charge_down,
   input wire logic [2:0] correction_charge,
   input wire logic       hold_current_n,
   input wire logic       afc_mode_flag,
   input wire logic       lock_flag,
   input wire logic       measure_window_n
);
   // ==========================================
   // Run-length counters
   int   run_r;    // Cycles at current window level
   logic mw_q_r;   // Window level one cycle back
   int   pulse_r;  // Cycles of the running pulse

   // Count level runs and pulse lengths
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 0;
         mw_q_r <= 1'b1;
         pulse_r <= 0;
      end else begin
         run_r <= (measure_window_n == mw_q_r) ? run_r + 1 : 1;
         mw_q_r <= measure_window_n;
         pulse_r <= (charge_up || charge_down) ? pulse_r + 1 : 0;
      end
   end

   // ==========================================
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_reset_state: assert property (
      $rose(arst_n) |-> band_ports_n == 4'hf && !hold_current_n && !afc_mode_flag && !lock_flag)
      else $error("outputs not in reset state");
   a_window_high: assert property (
      $fell(measure_window_n) |-> run_r == PROC_LEN)
      else $error("processing window length wrong");
   a_window_low: assert property (
      $rose(measure_window_n) |-> run_r == CYCLE_LEN - PROC_LEN)
      else $error("counting window length wrong");
   a_pulse_short: assert property (
      pulse_r < CYCLE_LEN)
      else $error("correction pulse longer than a cycle");
   a_pulse_min: assert property (
      $fell(charge_up || charge_down) && !afc_mode_flag |-> pulse_r >= MIN_PULSE_CYC)
      else $error("correction pulse too short");
   a_pulse_excl: assert property (
      !(charge_up && charge_down))
      else $error("both pulse directions at once");
   a_charge_eval: assert property (
      $changed(correction_charge) |-> measure_window_n)
      else $error("charge code moved outside evaluation");
   a_lock_eval: assert property (
      $changed(lock_flag) |-> measure_window_n)
      else $error("lock flag moved outside evaluation");
   a_data_scl_low: assert property (
      $changed(sda_oe) |-> !scl)
      else $error("data driver changed while clock high");
endmodule

bind fll_tuning_controller fll_tuning_controller_asserts #(
   .CYCLE_LEN(CYCLE_LEN),
   .PROC_LEN(PROC_LEN)
) i_fll_tuning_controller_asserts (
   .sys_clk, .arst_n, .scl, .sda_oe, .band_ports_n, .charge_up, .charge_down,
   .correction_charge, .hold_current_n, .afc_mode_flag, .lock_flag, .measure_window_n
);
`default_nettype wire

// [verification/fll_host_model.sv]
// Host controller model acting as two-wire bus master.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module fll_host_model (
   input  wire logic sys_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // Bus idles released, clock standing high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Step in system clocks at the falling edge
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // One bit: data set mid-low, sampled at end of high
   task automatic bit_io(input logic b, output logic r);
      wt(5);
      sda_low = !b;
      wt(5);
      scl = 1'b1;
      wt(10);
      r = sda;
      scl = 1'b0;
   endtask

   task automatic xact(input logic [23:0] tx, input int n, output logic [23:0] rx,
                       output logic [2:0] ak);
      logic a;
      rx = '1;
      ak = '0;
      wt(10);
      sda_low = 1'b1;
      wt(10);
      scl = 1'b0;
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) bit_io(tx[16-8*k+i], rx[16-8*k+i]);
         // slot left released, no master acknowledge
         bit_io(1'b1, a);
         ak[2-k] = !a;
      end
      wt(5);
      sda_low = 1'b1;
      wt(5);
      scl = 1'b1;
      wt(10);
      sda_low = 1'b0;
      wt(10);
   endtask
endmodule
`default_nettype wire

// [verification/fll_tuning_controller_tb.sv]
// Self-checking bench for the tuning controller.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module fll_tuning_controller_tb;
   import fll_pkg::*;
   localparam int CYC = 4000;
   logic sys_clk, arst_n, osc, port_lo, port_hi;
   wire logic scl, sda_low, sda_oe, sda_out, charge_up, charge_down;
   wire logic hold_current_n, afc_gain_sel, afc_mode_flag, lock_flag;
   wire logic [3:0] band_ports_n;
   wire logic [2:0] correction_charge;
   wire logic div_osc;
   wire logic sda = !((sda_oe && !sda_out) || sda_low);
   wire logic [3:0] flags = {lock_flag, charge_up, charge_down, afc_mode_flag};
   int n_errors = 0;
   int checks = 0;
   logic [23:0] rx;
   logic [2:0] ak;
   logic [7:0] st;

   fll_tuning_controller #(.CYCLE_LEN(CYC), .PROC_LEN(CYC/2)) i_fll_tuning_controller (
      .sys_clk, .arst_n, .osc_in_pos(osc), .osc_in_neg(!osc), .scl, .sda_in(sda),
      .sda_out, .sda_oe, .band_port_0_lo(port_lo), .band_port_0_hi(port_hi),
      .band_ports_n, .divided_osc(div_osc), .charge_up, .charge_down, .correction_charge,
      .hold_current_n, .afc_gain_sel, .afc_mode_flag, .lock_flag, .measure_window_n());
   fll_host_model i_fll_host_model (.sys_clk, .sda, .scl, .sda_low);

   // ==========================================
   // Clock (4 ns period) and oscillator (24 ns period)
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      osc = 1'b0;
      forever begin
         repeat (3) @(negedge sys_clk);
         osc = ~osc;
      end
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ins, input logic [7:0] dat);
      i_fll_host_model.xact({ADDR_HI, 3'b000, ins, dat}, 3, rx, ak);
      chk({5'h0, ak}, 8'h07); // three bytes acknowledged
   endtask
   task automatic rd(output logic [7:0] s);
      i_fll_host_model.xact({ADDR_HI, 3'b001, 16'hffff}, 3, rx, ak);
      s = rx[15:8];
      chk(rx[7:0], 8'hff); // bus idle after one byte
      chk({5'h0, ak}, 8'h04); // only the address acknowledged
   endtask
   task automatic wt_flag(input int idx, input logic lvl);
      for (int i = 0; i < 3*CYC && flags[idx] !== lvl; i++) @(negedge sys_clk);
      chk({7'h0, flags[idx]}, {7'h0, lvl});
      if (flags[idx] !== lvl) end_of_test();
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      int n;
      chk({band_ports_n, hold_current_n, afc_gain_sel, afc_mode_flag, lock_flag}, 8'hf0);
      rd(st);
      chk(st & 8'hfb, 8'h60); // reset seen low
      rd(st);
      chk(st & 8'hfb, 8'h68); // cleared after read
      for (int i = 0; i < 800 && div_osc !== 1'b0; i++) @(negedge sys_clk);
      for (int i = 0; i < 800 && div_osc !== 1'b1; i++) @(negedge sys_clk);
      for (n = 0; n < 800 && div_osc === 1'b1; n++) @(negedge sys_clk);
      chk(n[7:0], 8'(3 * PRESCALE_RATIO)); // high for 32 periods of 6 clocks
      $display("t_reset done");
   endtask
   task automatic t_addr;
      for (int lvl = 1; lvl < 4; lvl++) begin
         port_lo = (lvl == 1);
         port_hi = (lvl == 3);
         for (int sub = 0; sub < 4; sub++) begin
            i_fll_host_model.xact({ADDR_HI, sub[1:0], 1'b0, 16'hffff}, 1, rx, ak);
            chk({7'h0, ak[2]}, {7'h0, (sub == 0 || sub == lvl)}); // port level match
         end
      end
      i_fll_host_model.xact({~ADDR_HI, 3'b000, 16'hffff}, 1, rx, ak);
      chk({7'h0, ak[2]}, 8'h00); // foreign address refused
      $display("t_addr done");
   endtask
   task automatic t_ctrl;
      wr(INSTR_CTRL, 8'h4b);
      chk({6'h0, hold_current_n, afc_gain_sel}, 8'h03); // control bits
      wr(INSTR_BAND, 8'h05);
      chk({4'h0, band_ports_n}, 8'h0a); // set bits drive low
      i_fll_host_model.xact({ADDR_HI, 3'b000, 8'h03, 8'h00}, 3, rx, ak);
      chk({band_ports_n, 2'b00, hold_current_n, afc_gain_sel}, 8'ha3); // unknown code
      $display("t_ctrl done");
   endtask
   task automatic t_lock;
      wr(INSTR_CTRL, 8'h6b);
      wr(8'h80, 8'h05);
      wt_flag(3, 1'b1); // lock in window
      rd(st);
      chk(st & 8'heb, 8'ha8); // rise flag low
      wr(8'h80, 8'h64);
      wt_flag(2, 1'b1); // raising pulse
      chk({5'h0, correction_charge}, 8'h07); // charge code saturates
      wt_flag(3, 1'b0);
      rd(st);
      chk(st & 8'hfb, 8'h48); // fall flag, below target
      wr(8'h80, 8'h00);
      wt_flag(1, 1'b1); // lowering pulse
      rd(st);
      chk(st & 8'hfb, 8'h78); // above target
      $display("t_lock done");
   endtask
   task automatic t_afc;
      wr(8'h80, 8'h05);
      wr(INSTR_CTRL, 8'h7b);
      chk({7'h0, afc_mode_flag}, 8'h01); // AFC entered
      wt_flag(3, 1'b1); // inside hold range
      rd(st);
      chk(st & 8'h83, 8'h82); // mode in status
      wr(8'h80, 8'h64);
      wt_flag(0, 1'b0); // falls back to digital
      wr(8'h80, 8'h05);
      wr(INSTR_CTRL, 8'h7b); // host requests again
      chk({7'h0, afc_mode_flag}, 8'h01); // AFC regained
      $display("t_afc done");
   endtask

   // Reset for 10 cycles, then run every scenario
   initial begin
      arst_n = 1'b0;
      port_lo = 1'b0;
      port_hi = 1'b0;
      repeat (10) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_reset();
      t_addr();
      t_ctrl();
      t_lock();
      t_afc();
      end_of_test();
   end
endmodule
`default_nettype wire
